// ### include/psr_pkg.sv
// constants and carrier types for the port select / status register slice
package psr_pkg;

  // register offsets (I2C register pointer values)
  localparam logic [7:0] OFS_BC_ERR_CNT  = 8'h1B;
  localparam logic [7:0] OFS_GPIO_STAT_L = 8'h1C;
  localparam logic [7:0] OFS_GPIO_STAT_H = 8'h1D;
  localparam logic [7:0] OFS_PORT_SEL    = 8'h1E;
  localparam logic [7:0] OFS_PIX_MEAS    = 8'h1F;

  // reset values
  localparam logic [7:0] RST_BC_ERR_CNT = 8'h00;
  localparam logic [2:0] RST_PORT_SEL   = 3'h1;
  localparam logic [7:0] RST_PIX_MEAS   = 8'h00;

  // port select field positions
  localparam int PSEL_PRIMARY_BIT   = 0;
  localparam int PSEL_SECONDARY_BIT = 1;
  localparam int PSEL_SEC_ADDR_BIT  = 2;

  // counter saturation values
  localparam logic [7:0] BC_ERR_MAX  = 8'hFF;
  localparam logic [7:0] PIX_CNT_MAX = 8'hFF;

  // oscillator tick timing, derived from the system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PERIOD_NS = 40;
  localparam int OSC_TICK_CYC  = OSC_PERIOD_NS / CLK_PERIOD_NS;

  // I2C slave states
  typedef enum logic [3:0] {
    I2C_IDLE     = 4'b0000,
    I2C_ADDR     = 4'b0001,
    I2C_ACK_ADDR = 4'b0010,
    I2C_RX_PTR   = 4'b0011,
    I2C_ACK_PTR  = 4'b0100,
    I2C_RX_DATA  = 4'b0101,
    I2C_ACK_DATA = 4'b0110,
    I2C_TX_DATA  = 4'b0111,
    I2C_ACK_TX   = 4'b1000
  } psr_i2c_state_t;

  // general-purpose input pin levels, straight from the pads
  typedef struct packed {
    logic       pin8;
    logic       pin7;
    logic       pin6;
    logic       pin5;
    logic [3:0] firstLow;
    logic [3:0] secondLow;
  } psr_gpio_t;

  // routing of register accesses towards the two link ports
  typedef struct packed {
    logic wrFirst;
    logic wrSecond;
    logic rdSecond;
    logic gpioCtlSecond;
  } psr_route_t;

endpackage

// ### src/port_select_status_regs.sv
// port select, pin status, back-channel error and pixel clock measure registers
`timescale 1ns/10ps

// Overview of operation
// - in self-test mode each port counts back-channel CRC errors in 8 bits, saturating at 255.
// - both error counters clear when a self-test run starts or the external clear bit is written.
// - with the secondary port selected the error count register reads the second port's count.
// - status register 0x1C shows pins 7,6,5 in bits 7:5 and pins 3:0 in bits 3:0, bit 4 reserved.
// - status register 0x1D shows pin 8 in bit 0 with bits 7:1 reading zero.
// - with the secondary port selected status bits 3:0 show the second port's pins 3:0.
// - with secondary address enabled the device also answers at its own address plus one.
// - accesses at the secondary address reach the second port's and the shared registers.
// - with the secondary select, primary writes go to second port and shared, reads likewise.
// - with the secondary select, pin 3:0 control writes steer the second port's pins.
// - with the primary select writes reach the first port; with both set reads use the second.
// - both port selects are ignored while the secondary address is enabled.
// - writing the measure register counts pixel clock edges for value times 40 ns.
// - reading the measure register returns the edge count of the latest window.
// - the pixel clock edge count saturates at all ones.
module port_select_status_regs
  import psr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary value
)(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       selfTestActive,
  input  wire logic       selfTestStart,
  input  wire logic       errCountClear,
  input  wire logic [1:0] crcErr,
  input  wire psr_gpio_t  gpioPins,
  input  wire logic       pixClk,
  output psr_route_t      route,
  output logic            secAddrEnable
);

  logic           rstSync1_ff;
  logic           rstSync2_ff;
  logic [1:0]     sclSync_ff;
  logic [1:0]     sdaSync_ff;
  logic           sclPrev_ff;
  logic           sdaPrev_ff;
  psr_gpio_t      gpioSync1_ff;
  psr_gpio_t      gpioSync2_ff;
  logic [2:0]     pixSync_ff;
  psr_i2c_state_t state_ff;
  logic [3:0]     bitCnt_ff;
  logic [7:0]     rxSh_ff;
  logic [7:0]     txSh_ff;
  logic [7:0]     ptr_ff;
  logic           isRead_ff;
  logic           viaSecond_ff;
  logic           oe_ff;
  logic           sdaOut_ff;
  logic [2:0]     portSel_ff;
  logic [7:0]     errCnt_ff [2];
  logic [7:0]     window_ff;
  logic [7:0]     pixCnt_ff;
  logic           measuring_ff;
  logic [7:0]     tickCnt_ff;
  psr_route_t     route_ff;
  logic           secAddr_ff;

  // synchronised reset copy used throughout
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end
    else
    begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end

  wire rstnInt = rstSync2_ff;

  // pad inputs pass two flip-flops before any logic reads them
  always_ff @(posedge mclk or negedge rstnInt)
  begin
    if (!rstnInt)
    begin
      sclSync_ff   <= 2'h3;
      sdaSync_ff   <= 2'h3;
      sclPrev_ff   <= 1'b1;
      sdaPrev_ff   <= 1'b1;
      gpioSync1_ff <= '0;
      gpioSync2_ff <= '0;
      pixSync_ff   <= 3'h0;
    end
    else
    begin
      sclSync_ff   <= {sclSync_ff[0], scl};
      sdaSync_ff   <= {sdaSync_ff[0], sdaIn};
      sclPrev_ff   <= sclSync_ff[1];
      sdaPrev_ff   <= sdaSync_ff[1];
      gpioSync1_ff <= gpioPins;
      gpioSync2_ff <= gpioSync1_ff;
      pixSync_ff   <= {pixSync_ff[1:0], pixClk};
    end
  end

  wire sclNow   = sclSync_ff[1];
  wire sdaNow   = sdaSync_ff[1];
  wire sclRise  = sclNow & ~sclPrev_ff;
  wire sclFall  = ~sclNow & sclPrev_ff;
  wire startCnd = sclNow & sclPrev_ff & sdaPrev_ff & ~sdaNow;
  wire stopCnd  = sclNow & sclPrev_ff & ~sdaPrev_ff & sdaNow;
  wire byteDone = (bitCnt_ff == 4'h8);

  // port routing
  wire secEn      = portSel_ff[PSEL_SEC_ADDR_BIT];
  wire selFirst   = portSel_ff[PSEL_PRIMARY_BIT] | secEn;
  wire selSecond  = portSel_ff[PSEL_SECONDARY_BIT] & ~secEn;
  wire matchPrim  = (rxSh_ff[7:1] == DEV_ADDR);
  wire [6:0] secAddr = DEV_ADDR + 7'h01;
  wire matchSec   = secEn & (rxSh_ff[7:1] == secAddr);
  wire rdSecond   = viaSecond_ff | selSecond;

  psr_route_t nxt_route;
  always_comb
  begin
    nxt_route.wrFirst       = ~viaSecond_ff & selFirst;
    nxt_route.wrSecond      = viaSecond_ff | selSecond;
    nxt_route.rdSecond      = rdSecond;
    nxt_route.gpioCtlSecond = viaSecond_ff | selSecond;
  end

  // read data selection
  wire [7:0] errSel  = rdSecond ? errCnt_ff[1] : errCnt_ff[0];
  wire [3:0] lowPins = rdSecond ? gpioSync2_ff.secondLow : gpioSync2_ff.firstLow;
  wire [7:0] statL   = {gpioSync2_ff.pin7, gpioSync2_ff.pin6, gpioSync2_ff.pin5,
                        1'b0, lowPins};
  wire [7:0] statH   = {7'h00, gpioSync2_ff.pin8};

  function automatic logic [7:0] readReg(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      OFS_BC_ERR_CNT:  d = errSel;
      OFS_GPIO_STAT_L: d = statL;
      OFS_GPIO_STAT_H: d = statH;
      OFS_PORT_SEL:    d = {5'h00, portSel_ff};
      OFS_PIX_MEAS:    d = pixCnt_ff;
      default:         d = 8'h00;
    endcase
    return d;
  endfunction

  wire [7:0] rdData = readReg(ptr_ff);
  wire       wrStb  = sclFall & (state_ff == I2C_RX_DATA) & byteDone;
  wire       wrSel  = wrStb & (ptr_ff == OFS_PORT_SEL);
  wire       wrMeas = wrStb & (ptr_ff == OFS_PIX_MEAS);

  // I2C slave; bits shift in on SCL rise, SDA changes after SCL fall
  always_ff @(posedge mclk or negedge rstnInt)
  begin
    if (!rstnInt)
    begin
      state_ff     <= I2C_IDLE;
      bitCnt_ff    <= 4'h0;
      rxSh_ff      <= 8'h00;
      txSh_ff      <= 8'h00;
      ptr_ff       <= 8'h00;
      isRead_ff    <= 1'b0;
      viaSecond_ff <= 1'b0;
      oe_ff        <= 1'b0;
    end
    else if (startCnd)
    begin
      state_ff  <= I2C_ADDR;
      bitCnt_ff <= 4'h0;
      oe_ff     <= 1'b0;
    end
    else if (stopCnd)
    begin
      state_ff     <= I2C_IDLE;
      oe_ff        <= 1'b0;
      viaSecond_ff <= 1'b0;
    end
    else if (sclRise)
    begin
      rxSh_ff   <= {rxSh_ff[6:0], sdaNow};
      bitCnt_ff <= bitCnt_ff + 4'h1;
      if (state_ff == I2C_ACK_TX && !sdaNow)
        ptr_ff <= ptr_ff + 8'h01;
    end
    else if (sclFall)
    begin
      unique case (state_ff)
        I2C_IDLE: ;
        I2C_ADDR:
          if (byteDone)
          begin
            if (matchPrim || matchSec)
            begin
              state_ff     <= I2C_ACK_ADDR;
              oe_ff        <= 1'b1;
              isRead_ff    <= rxSh_ff[0];
              viaSecond_ff <= matchSec & ~matchPrim;
            end
            else
              state_ff <= I2C_IDLE;
          end
        I2C_ACK_ADDR:
        begin
          bitCnt_ff <= 4'h0;
          if (isRead_ff)
          begin
            state_ff <= I2C_TX_DATA;
            txSh_ff  <= rdData;
            oe_ff    <= ~rdData[7];
          end
          else
          begin
            state_ff <= I2C_RX_PTR;
            oe_ff    <= 1'b0;
          end
        end
        I2C_RX_PTR:
          if (byteDone)
          begin
            ptr_ff   <= rxSh_ff;
            oe_ff    <= 1'b1;
            state_ff <= I2C_ACK_PTR;
          end
        I2C_ACK_PTR, I2C_ACK_DATA:
        begin
          bitCnt_ff <= 4'h0;
          oe_ff     <= 1'b0;
          state_ff  <= I2C_RX_DATA;
        end
        I2C_RX_DATA:
          if (byteDone)
          begin
            ptr_ff   <= ptr_ff + 8'h01;
            oe_ff    <= 1'b1;
            state_ff <= I2C_ACK_DATA;
          end
        I2C_TX_DATA:
          if (byteDone)
          begin
            oe_ff    <= 1'b0;
            state_ff <= I2C_ACK_TX;
          end
          else
          begin
            txSh_ff <= {txSh_ff[6:0], 1'b0};
            oe_ff   <= ~txSh_ff[6];
          end
        I2C_ACK_TX:
          // master ack moved the pointer on the rise; a nack ends the read
          if (!sdaPrev_ff)
          begin
            bitCnt_ff <= 4'h0;
            txSh_ff   <= rdData;
            oe_ff     <= ~rdData[7];
            state_ff  <= I2C_TX_DATA;
          end
          else
            state_ff <= I2C_IDLE;
        default: state_ff <= I2C_IDLE;
      endcase
    end
  end

  // shared register and routing outputs
  always_ff @(posedge mclk or negedge rstnInt)
  begin
    if (!rstnInt)
    begin
      portSel_ff <= RST_PORT_SEL;
      route_ff   <= '0;
      secAddr_ff <= 1'b0;
      sdaOut_ff  <= 1'b0;
    end
    else
    begin
      if (wrSel)
        portSel_ff <= rxSh_ff[2:0];
      route_ff   <= nxt_route;
      secAddr_ff <= secEn;
      sdaOut_ff  <= 1'b0;
    end
  end

  // back-channel error counters; an error in the clearing cycle still counts
  wire errClr = selfTestStart | errCountClear;

  for (genvar p = 0; p < 2; p++)
  begin : g_err
    wire errHit = selfTestActive & crcErr[p];
    always_ff @(posedge mclk or negedge rstnInt)
    begin
      if (!rstnInt)
        errCnt_ff[p] <= RST_BC_ERR_CNT;
      else if (errClr)
        errCnt_ff[p] <= {7'h00, errHit};
      else if (errHit && errCnt_ff[p] != BC_ERR_MAX)
        errCnt_ff[p] <= errCnt_ff[p] + 8'h01;
    end
  end

  // pixel clock measure; edges are seen through the synchroniser, so pixel
  // clocks above half of mclk alias and the figure is only a rough estimate
  wire pixEdge = pixSync_ff[1] & ~pixSync_ff[2];
  wire oscTick = (tickCnt_ff == 8'(OSC_TICK_CYC - 1));

  always_ff @(posedge mclk or negedge rstnInt)
  begin
    if (!rstnInt)
    begin
      window_ff    <= 8'h00;
      pixCnt_ff    <= RST_PIX_MEAS;
      measuring_ff <= 1'b0;
      tickCnt_ff   <= 8'h00;
    end
    else if (wrMeas)
    begin
      window_ff    <= rxSh_ff;
      pixCnt_ff    <= 8'h00;
      measuring_ff <= (rxSh_ff != 8'h00);
      tickCnt_ff   <= 8'h00;
    end
    else if (measuring_ff)
    begin
      tickCnt_ff <= oscTick ? 8'h00 : tickCnt_ff + 8'h01;
      if (pixEdge && pixCnt_ff != PIX_CNT_MAX)
        pixCnt_ff <= pixCnt_ff + 8'h01;
      if (oscTick)
      begin
        window_ff <= window_ff - 8'h01;
        if (window_ff == 8'h01)
          measuring_ff <= 1'b0;
      end
    end
  end

  assign sdaOe         = oe_ff;
  assign sdaOut        = sdaOut_ff;
  assign route         = route_ff;
  assign secAddrEnable = secAddr_ff;

endmodule // port_select_status_regs

// ### verif/port_select_status_regs_tb_top.sv
// self-checking bench for the port select and status register slice
`timescale 1ns/10ps
module port_select_status_regs_tb_top
  import psr_pkg::*;
();
  // arbitrary device address
  localparam logic [6:0] DEV = 7'h2A;
  logic       mclk;
  logic       rstn;
  logic       scl;
  logic       sdaIn;
  logic       sdaOut;
  logic       sdaOe;
  logic       testOn;
  logic [3:0] ev;
  psr_gpio_t  pins;
  logic       pixRun;
  logic       pixClk;
  psr_route_t route;
  logic       secAddrEnable;
  logic       nak;
  logic [7:0] v;
  int         errCount;
  int         totalChecks;
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  always @(negedge mclk) pixClk <= pixRun & ~pixClk;
  port_select_status_regs #(.DEV_ADDR(DEV)) u_port_select_status_regs (
    .mclk(mclk), .rstn(rstn), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .selfTestActive(testOn), .selfTestStart(ev[3]), .errCountClear(ev[2]),
    .crcErr(ev[1:0]), .gpioPins(pins), .pixClk(pixClk), .route(route),
    .secAddrEnable(secAddrEnable));
  psr_i2c_host u_psr_i2c_host (.mclk(mclk), .scl(scl), .sdaIn(sdaIn), .sdaOe(sdaOe));
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] d, input logic [7:0] p, input logic [7:0] x);
    u_psr_i2c_host.acc(d, p, x, 1'h0, v, nak);
    check({7'h0, nak}, 8'h00);
  endtask
  task automatic rdc(input logic [6:0] d, input logic [7:0] p, input logic [7:0] x);
    u_psr_i2c_host.acc(d, p, 8'h00, 1'h1, v, nak);
    check({7'h0, nak}, 8'h00);
    check(v, x);
  endtask
  task automatic pulse(input logic [3:0] x);
    @(negedge mclk);
    ev = x;
    @(negedge mclk);
    ev = 4'h0;
  endtask
  task automatic resetScn();
    rdc(DEV, OFS_BC_ERR_CNT, RST_BC_ERR_CNT);
    rdc(DEV, OFS_PORT_SEL, {5'h0, RST_PORT_SEL});
    rdc(DEV, OFS_PIX_MEAS, RST_PIX_MEAS);
    rdc(DEV, 8'h20, 8'h00);
  endtask
  task automatic gpioScn();
    rdc(DEV, OFS_GPIO_STAT_L, 8'hAA);
    rdc(DEV, OFS_GPIO_STAT_H, 8'h01);
    pins = 12'h53C;
    rdc(DEV, OFS_GPIO_STAT_L, 8'hA3);
    rdc(DEV, OFS_GPIO_STAT_H, 8'h00);
    wr(DEV, OFS_PORT_SEL, 8'h02);
    check({4'h0, route}, 8'h07);
    rdc(DEV, OFS_GPIO_STAT_L, 8'hAC);
    wr(DEV, OFS_PORT_SEL, 8'h03);
    check({4'h0, route}, 8'h0F);
    rdc(DEV, OFS_GPIO_STAT_L, 8'hAC);
    wr(DEV, OFS_PORT_SEL, 8'h01);
    rdc(DEV, OFS_GPIO_STAT_L, 8'hA3);
  endtask
  task automatic errScn();
    testOn = 1'h1;
    for (int i = 0; i < 300; i++)
      pulse({3'h1, i < 3});
    rdc(DEV, OFS_BC_ERR_CNT, 8'h03);
    wr(DEV, OFS_PORT_SEL, 8'h02);
    rdc(DEV, OFS_BC_ERR_CNT, BC_ERR_MAX);
    pulse(4'h4);
    pulse(4'h2);
    pulse(4'h2);
    rdc(DEV, OFS_BC_ERR_CNT, 8'h02);
    pulse(4'h8);
    testOn = 1'h0;
    pulse(4'h2);
    rdc(DEV, OFS_BC_ERR_CNT, 8'h00);
    wr(DEV, OFS_PORT_SEL, 8'h01);
  endtask
  task automatic measScn();
    pixRun = 1'h1;
    wr(DEV, OFS_PIX_MEAS, 8'd10);
    u_psr_i2c_host.acc(DEV, OFS_PIX_MEAS, 8'h00, 1'h1, v, nak);
    check({7'h0, nak}, 8'h00);
    check({7'h0, v inside {8'd19, 8'd20, 8'd21}}, 8'h01);
    rdc(DEV, OFS_PIX_MEAS, v);
    wr(DEV, OFS_PIX_MEAS, 8'd200);
    // window of 800 cycles must be over before the read
    repeat (1000) @(negedge mclk);
    rdc(DEV, OFS_PIX_MEAS, PIX_CNT_MAX);
    wr(DEV, OFS_PIX_MEAS, 8'h00);
    rdc(DEV, OFS_PIX_MEAS, 8'h00);
    pixRun = 1'h0;
  endtask
  task automatic secScn();
    u_psr_i2c_host.acc(DEV + 7'h1, OFS_GPIO_STAT_L, 8'h00, 1'h1, v, nak);
    check({7'h0, nak}, 8'h01);
    wr(DEV, OFS_PORT_SEL, 8'h04);
    check({7'h0, secAddrEnable}, 8'h01);
    rdc(DEV + 7'h1, OFS_GPIO_STAT_L, 8'hAC);
    wr(DEV, OFS_PORT_SEL, 8'h06);
    check({4'h0, route}, 8'h08);
    rdc(DEV, OFS_GPIO_STAT_L, 8'hA3);
    wr(DEV + 7'h1, OFS_PORT_SEL, 8'h03);
    check({7'h0, secAddrEnable}, 8'h00);
    rdc(DEV, OFS_PORT_SEL, 8'h03);
  endtask
  task automatic midResetScn();
    rstn = 1'h0;
    repeat (3) @(negedge mclk);
    rstn = 1'h1;
    repeat (10) @(negedge mclk);
    rdc(DEV, OFS_PORT_SEL, {5'h0, RST_PORT_SEL});
  endtask
  initial
  begin
    repeat (90000) @(posedge mclk);
    errCount++;
    conclude();
  end
  initial
  begin
    {rstn, testOn, ev, pixRun} = '0;
    pins = 12'hDA5;
    errCount = 0;
    totalChecks = 0;
    repeat (20) @(negedge mclk);
    rstn = 1'h1;
    repeat (10) @(negedge mclk);
    resetScn();
    gpioScn();
    errScn();
    measScn();
    secScn();
    midResetScn();
    conclude();
  end
endmodule // port_select_status_regs_tb_top

// ### verif/psr_i2c_host.sv
// I2C host model standing on the slice's local bus
`timescale 1ns/10ps
module psr_i2c_host (
  input  wire logic mclk,
  output logic      scl,
  output logic      sdaIn,
  input  wire logic sdaOe
);
  logic hostSda = 1'h1;
  // a released line is pulled high
  assign sdaIn = hostSda & ~sdaOe;
  initial scl = 1'h1;
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // start or repeated start (s=1), stop (s=0); sda moves only with scl low first
  task automatic cond(input logic s);
    hold(2);
    hostSda = s;
    hold(8);
    scl = 1'h1;
    hold(8);
    hostSda = ~s;
    hold(8);
    scl = ~s;
  endtask
  // eight bits then the ack bit, msb first
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      hold(2);
      hostSda = tx[i];
      hold(8);
      scl = 1'h1;
      hold(8);
      rx[i] = sdaIn;
      scl = 1'h0;
    end
  endtask
  // one-byte write, or one-byte read closed by a nack
  task automatic acc(input logic [6:0] d, input logic [7:0] p, input logic [7:0] x,
                     input logic rdOp, output logic [7:0] y, output logic nak);
    logic [8:0] r [4];
    cond(1'h1);
    xfer({d, 2'h1}, r[0]);
    xfer({p, 1'h1}, r[1]);
    if (rdOp)
    begin
      cond(1'h1);
      xfer({d, 2'h3}, r[2]);
      xfer(9'h1FF, r[3]);
    end
    else
      xfer({x, 1'h1}, r[2]);
    cond(1'h0);
    y = r[3][8:1];
    nak = r[0][0] | r[1][0] | r[2][0];
  endtask
endmodule // psr_i2c_host

// ### verif/psr_regs_assertions.sv
// port assertions for the register slice
`timescale 1ns/10ps
module psr_regs_assertions
  import psr_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       scl,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire psr_route_t route,
  input wire logic       secAddrEnable
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  quiet_reset_a: assert property (disable iff (1'h0)
    !rstn |-> !sdaOe && {route} == 4'h0 && !secAddrEnable) else $error("active in reset");
  reset_route_a: assert property ($rose(rstn) |-> ##[1:5] {route} == 4'h8)
    else $error("route not first port after reset");
  oe_after_fall_a: assert property ($changed(sdaOe) |-> !scl && !$past(scl) && !$past(scl, 2))
    else $error("sda enable moved near scl high");
  sda_low_only_a: assert property (sdaOut == 1'h0)
    else $error("sda driven high");
  rd_needs_wr_a: assert property (route.rdSecond |-> route.wrSecond)
    else $error("second read without second write");
  gpio_with_rd_a: assert property (route.gpioCtlSecond == route.rdSecond)
    else $error("pin control not following select");
  sec_ignores_sel_a: assert property (secAddrEnable && $past(secAddrEnable, 2)
    && !route.rdSecond |-> route.wrFirst && !route.wrSecond) else $error("select not ignored");
  sec_en_scl_a: assert property ($changed(secAddrEnable) |-> !scl && !$past(scl))
    else $error("address enable moved with scl high");
  rd_second_c: cover property (route.rdSecond);
  sec_addr_c: cover property ($rose(secAddrEnable));
  ack_c: cover property ($rose(sdaOe));
endmodule // psr_regs_assertions
bind port_select_status_regs psr_regs_assertions u_psr_regs_assertions (
  .mclk(mclk), .rstn(rstn), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe), .route(route),
  .secAddrEnable(secAddrEnable));
